// ===== src/ptp_consts.svh
// Offsets, field positions, reset values and counts of the positioning table block
`ifndef PTP_CONSTS_SVH
`define PTP_CONSTS_SVH
`define PTP_AXES 8
`define PTP_BANK_SHIFT 10
`define PTP_BANK_FIRST 8'h02
`define PTP_BANK_STEP 8'h0a
`define PTP_OFF_CEIL_LO 10'h048
`define PTP_OFF_CEIL_HI 10'h049
`define PTP_OFF_ORIG_LO 10'h04a
`define PTP_OFF_ORIG_HI 10'h04b
`define PTP_STD_PTS 10'h258
`define PTP_EXT_PTS 10'h019
`define PTP_ALL_PTS 10'h271
`define PTP_STD_FIRST 14'h0001
`define PTP_EXT_FIRST 14'h2711
`define PTP_CEIL_MAX 32'h01f3_fc18
`define PTP_CEIL_RST 32'h0000_0000
`define PTP_MIN_SPEED 32'h0000_0001
`define PTP_EXT_BASE_LAT 5'h04
`endif

// ===== src/ptp_pkg.sv
// Types shared by the positioning table block
package ptp_pkg;
    typedef enum logic [1:0] {
        PTP_IDLE = 2'h0,
        PTP_COPY = 2'h1,
        PTP_DONE = 2'h3
    } ptp_state_e;

    typedef struct packed {
        logic [2:0] axis;
        logic [13:0] point;
        logic [3:0] chain;
    } ptp_start_s;

    typedef struct packed {
        logic [2:0] axis;
        logic [13:0] point;
        logic ext;
        logic [15:0] data;
    } ptp_run_s;

    typedef struct packed {
        logic hit_param;
        logic hit_tbl;
        logic [2:0] axis;
        logic [9:0] off;
    } ptp_dec_s;

    typedef struct packed {
        logic ok;
        logic ext;
        logic [9:0] idx;
    } ptp_pt_s;
endpackage : ptp_pkg

// ===== src/ptp_speed_clamp.sv
// Pulser speed from ratio, limited by the programmed ceiling
`timescale 1ns/10ps
`include "ptp_consts.svh"
module ptp_speed_clamp import ptp_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic [15:0] i_rate,
    input wire logic [15:0] i_num,
    input wire logic [15:0] i_den,
    input wire logic i_limit,
    input wire logic [31:0] i_ceiling,
    output logic [31:0] o_speed
);
    logic [31:0] prod;
    logic [31:0] raw;
    logic [31:0] eff;
    logic [31:0] speed_nxt;

    // Zero denominator is an error setting; raw speed is zero rather than a divide fault
    assign prod = i_rate * i_num;
    assign raw = (i_den == 16'h0000) ? 32'h0000_0000 : prod / {16'h0000, i_den};
    // Over-range ceilings saturate here; the written value is stored as is
    assign eff = (i_ceiling > `PTP_CEIL_MAX) ? `PTP_CEIL_MAX : i_ceiling;
    assign speed_nxt = !i_limit ? raw :
                       (eff == 32'h0000_0000) ? `PTP_MIN_SPEED :
                       (raw > eff) ? eff : raw;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_speed <= 32'h0000_0000;
        end else if (i_ce) begin
            o_speed <= speed_nxt;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    speed_ceiling_a: assert property (i_ce && i_limit && eff != 32'h0000_0000 |=> o_speed <= $past(eff))
        else $error("pulser speed above ceiling");
    zero_ceiling_a: assert property (i_ce && i_limit && i_ceiling == 32'h0000_0000 |=> o_speed == `PTP_MIN_SPEED)
        else $error("zero ceiling did not give minimum speed");
    clamp_hit_c: cover property (i_ce && i_limit && raw > eff && eff != 32'h0000_0000);
endmodule : ptp_speed_clamp

// ===== src/ptp_top.sv
// Per-axis positioning parameters, table storage and recalculation handshake
// Operation
// - Limited pulser speed above the programmed ceiling runs at the ceiling instead.
// - Ceiling is a 32-bit word pair at offset 048H, range 0 to 32767000.
// - Ceiling resets to zero; zero means run the pulser at minimum speed.
// - Home return completion stores the coordinate origin at offset 04AH.
// - Axis parameter banks start at 02H and step 0AH up to 48H.
// - Eight axes, each with its own 625 table points.
// - Standard area is point numbers 1 to 600.
// - Extended area is point numbers 10001 to 10025.
// - Host gives point number and start; device runs from that entry.
// - Standard entries are prepared in advance, so they start faster.
// - Host raises recalculation request and waits for done before using new data.
// - Without recalculation the previously restructured standard table stays in use.
// - Extended entries are used as written at start, no recalculation.
// - Extended starts take longer, growing with consecutive entries executed.
`timescale 1ns/10ps
`include "ptp_consts.svh"
module ptp_top import ptp_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_mem_wr,
    input wire logic i_mem_rd,
    input wire logic [17:0] i_mem_addr,
    input wire logic [15:0] i_mem_wdata,
    output logic [15:0] o_mem_rdata,
    output logic o_mem_rvalid,
    input wire logic i_recalc_req,
    output logic o_recalc_done,
    input wire logic i_start,
    input wire ptp_start_s i_start_req,
    output logic o_start_busy,
    output logic o_start_err,
    output logic o_run_valid,
    output ptp_run_s o_run,
    input wire logic i_home_done,
    input wire logic [2:0] i_home_axis,
    input wire logic [31:0] i_home_pos,
    input wire logic [2:0] i_pulser_axis,
    input wire logic [15:0] i_pulser_rate,
    input wire logic [15:0] i_ratio_num,
    input wire logic [15:0] i_ratio_den,
    input wire logic i_speed_limit,
    output logic [31:0] o_pulser_speed
);
    // Flip-flop storage is large; entries hold one word each to keep the area sane
    logic [15:0] live_std_r [`PTP_AXES][600];
    logic [15:0] shadow_r [`PTP_AXES][600];
    logic [15:0] live_ext_r [`PTP_AXES][25];
    logic [31:0] ceil_r [`PTP_AXES];
    logic [31:0] origin_r [`PTP_AXES];
    ptp_state_e state_r, state_nxt;
    logic [9:0] copy_r;
    logic pend_r;
    logic [4:0] wait_r;
    ptp_run_s pend_run_r;

    function automatic ptp_dec_s decode(input logic [17:0] addr);
        ptp_dec_s d;
        logic [7:0] bank;
        d = '0;
        bank = addr[17:`PTP_BANK_SHIFT];
        d.off = addr[`PTP_BANK_SHIFT-1:0];
        for (int a = 0; a < `PTP_AXES; a++) begin
            if (bank == 8'(`PTP_BANK_FIRST + 8'(a) * `PTP_BANK_STEP)) begin
                d.hit_param = 1'b1;
                d.axis = 3'(a);
            end else if (bank == 8'(`PTP_BANK_FIRST + 8'(a) * `PTP_BANK_STEP + 8'h01)) begin
                d.hit_tbl = 1'b1;
                d.axis = 3'(a);
            end
        end
        return d;
    endfunction : decode

    function automatic ptp_pt_s point_index(input logic [13:0] pt);
        ptp_pt_s p;
        p = '0;
        if (pt >= `PTP_STD_FIRST && pt < `PTP_STD_FIRST + 14'(`PTP_STD_PTS)) begin
            p.ok = 1'b1;
            p.idx = 10'(pt - `PTP_STD_FIRST);
        end else if (pt >= `PTP_EXT_FIRST && pt < `PTP_EXT_FIRST + 14'(`PTP_EXT_PTS)) begin
            p.ok = 1'b1;
            p.ext = 1'b1;
            p.idx = 10'(pt - `PTP_EXT_FIRST);
        end
        return p;
    endfunction : point_index

    wire ptp_dec_s dec = decode(i_mem_addr);
    wire wr_ce = i_ce && i_mem_wr;
    wire tbl_std = dec.hit_tbl && dec.off < `PTP_STD_PTS;
    wire tbl_ext = dec.hit_tbl && dec.off >= `PTP_STD_PTS && dec.off < `PTP_ALL_PTS;
    wire [9:0] ext_off = dec.off - `PTP_STD_PTS;
    wire ceil_lo_wr = wr_ce && dec.hit_param && dec.off == `PTP_OFF_CEIL_LO;
    wire ceil_hi_wr = wr_ce && dec.hit_param && dec.off == `PTP_OFF_CEIL_HI;
    wire ptp_pt_s spt = point_index(i_start_req.point);
    wire start_acc = i_ce && i_start && !pend_r;
    wire copy_last = copy_r == `PTP_STD_PTS - 10'h001;

    // Read data, low word at the even offset
    wire [15:0] rd_mux =
        !dec.hit_param && !dec.hit_tbl ? 16'h0000 :
        dec.hit_param && dec.off == `PTP_OFF_CEIL_LO ? ceil_r[dec.axis][15:0] :
        dec.hit_param && dec.off == `PTP_OFF_CEIL_HI ? ceil_r[dec.axis][31:16] :
        dec.hit_param && dec.off == `PTP_OFF_ORIG_LO ? origin_r[dec.axis][15:0] :
        dec.hit_param && dec.off == `PTP_OFF_ORIG_HI ? origin_r[dec.axis][31:16] :
        tbl_std ? live_std_r[dec.axis][dec.off] :
        tbl_ext ? live_ext_r[dec.axis][ext_off[4:0]] : 16'h0000;

    // Standard starts read the restructured copy, extended ones the live words
    wire [15:0] start_data = spt.ext ? live_ext_r[i_start_req.axis][spt.idx[4:0]] :
                                       shadow_r[i_start_req.axis][spt.idx];
    wire [4:0] start_wait = spt.ext ? `PTP_EXT_BASE_LAT + {1'b0, i_start_req.chain} : 5'h00;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PTP_IDLE: begin
                if (i_recalc_req) begin
                    state_nxt = PTP_COPY;
                end
            end
            PTP_COPY: begin
                if (copy_last) begin
                    state_nxt = PTP_DONE;
                end
            end
            PTP_DONE: begin
                if (!i_recalc_req) begin
                    state_nxt = PTP_IDLE;
                end
            end
            default: state_nxt = PTP_IDLE;
        endcase
    end

    assign o_recalc_done = state_r == PTP_DONE;
    assign o_start_busy = pend_r;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_r <= PTP_IDLE;
            copy_r <= 10'h000;
        end else if (i_ce) begin
            state_r <= state_nxt;
            copy_r <= (state_r == PTP_COPY && !copy_last) ? copy_r + 10'h001 : 10'h000;
        end
    end

    // Restructure: one standard entry per cycle across all axes
    always_ff @(posedge i_clk) begin
        if (i_ce && state_r == PTP_COPY) begin
            for (int a = 0; a < `PTP_AXES; a++) begin
                shadow_r[a][copy_r] <= live_std_r[a][copy_r];
            end
        end
    end

    // Table contents have no reset; software loads them before use
    always_ff @(posedge i_clk) begin
        if (wr_ce && tbl_std) begin
            live_std_r[dec.axis][dec.off] <= i_mem_wdata;
        end
        if (wr_ce && tbl_ext) begin
            live_ext_r[dec.axis][ext_off[4:0]] <= i_mem_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int a = 0; a < `PTP_AXES; a++) begin
                ceil_r[a] <= `PTP_CEIL_RST;
                origin_r[a] <= 32'h0000_0000;
            end
        end else if (i_ce) begin
            if (ceil_lo_wr) begin
                ceil_r[dec.axis][15:0] <= i_mem_wdata;
            end
            if (ceil_hi_wr) begin
                ceil_r[dec.axis][31:16] <= i_mem_wdata;
            end
            if (i_home_done) begin
                origin_r[i_home_axis] <= i_home_pos;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_mem_rdata <= 16'h0000;
            o_mem_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_mem_rdata <= i_mem_rd ? rd_mux : o_mem_rdata;
            o_mem_rvalid <= i_mem_rd;
        end
    end

    // Start path: one start in flight, further starts ignored while busy
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pend_r <= 1'b0;
            wait_r <= 5'h00;
            pend_run_r <= '0;
            o_run_valid <= 1'b0;
            o_run <= '0;
            o_start_err <= 1'b0;
        end else if (i_ce) begin
            o_start_err <= start_acc && !spt.ok;
            o_run_valid <= pend_r && wait_r == 5'h00;
            if (pend_r && wait_r == 5'h00) begin
                o_run <= pend_run_r;
                pend_r <= 1'b0;
            end else if (pend_r) begin
                wait_r <= wait_r - 5'h01;
            end else if (start_acc && spt.ok) begin
                pend_r <= 1'b1;
                wait_r <= start_wait;
                pend_run_r <= '{axis: i_start_req.axis, point: i_start_req.point, ext: spt.ext, data: start_data};
            end
        end
    end

    ptp_speed_clamp u_clamp (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_rate(i_pulser_rate),
        .i_num(i_ratio_num),
        .i_den(i_ratio_den),
        .i_limit(i_speed_limit),
        .i_ceiling(ceil_r[i_pulser_axis]),
        .o_speed(o_pulser_speed)
    );

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    recalc_hold_a: assert property (o_recalc_done && i_recalc_req && i_ce |=> o_recalc_done)
        else $error("done dropped while request held");
    recalc_drop_a: assert property (o_recalc_done && !i_recalc_req && i_ce |=> !o_recalc_done ##1 !o_recalc_done)
        else $error("done stayed after request dropped");
    recalc_time_a: assert property (state_r == PTP_IDLE && i_recalc_req && i_ce |=> !o_recalc_done[*8])
        else $error("done came before restructure finished");
    shadow_keep_a: assert property (state_r != PTP_COPY && !i_recalc_req |=> shadow_r[0][0] === $past(shadow_r[0][0]))
        else $error("restructured table changed without request");
    std_fast_a: assert property (start_acc && spt.ok && !spt.ext |=> ##1 o_run_valid && !o_run.ext)
        else $error("standard start not issued in two cycles");
    ext_slow_a: assert property (start_acc && spt.ok && spt.ext && i_start_req.chain == 4'h0 |=>
        (!o_run_valid) [*5] ##1 (o_run_valid && o_run.ext))
        else $error("extended start too fast");
    origin_store_a: assert property (i_home_done && i_ce |=> origin_r[$past(i_home_axis)] == $past(i_home_pos))
        else $error("origin not stored");
    ceil_write_a: assert property (ceil_lo_wr && dec.axis == 3'h0 |=> ceil_r[0][15:0] == $past(i_mem_wdata))
        else $error("ceiling low word not written");
    bad_point_a: assert property (start_acc && !spt.ok |=> o_start_err ##1 !o_run_valid)
        else $error("invalid point not refused");

    recalc_c: cover property (state_r == PTP_IDLE && i_recalc_req ##1 state_r == PTP_COPY);
    ext_run_c: cover property (o_run_valid && o_run.ext);
    std_run_c: cover property (o_run_valid && !o_run.ext);
endmodule : ptp_top

// ===== bench/ptp_host_model.sv
// Host side model that drives the recalculation request handshake
`timescale 1ns/10ps
module ptp_host_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_go,
    input wire logic i_recalc_done,
    output logic o_recalc_req,
    output logic o_idle,
    output logic [15:0] o_wait
);
    // Idle only once done has fallen, so a new request never meets a stale done
    assign o_idle = !o_recalc_req && !i_recalc_done;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_recalc_req <= 1'b0;
            o_wait <= 16'h0000;
        end else if (!o_recalc_req) begin
            o_recalc_req <= i_go && !i_recalc_done;
            // Count survives the drop so it can be read once the handshake is idle
            if (i_go && !i_recalc_done) begin
                o_wait <= 16'h0000;
            end
        end else if (i_recalc_done) begin
            o_recalc_req <= 1'b0;
        end else begin
            o_wait <= o_wait + 16'h0001;
        end
    end
endmodule : ptp_host_model

// ===== bench/testbench.sv
// Self-checking bench for the positioning table block
`timescale 1ns/10ps
`include "ptp_consts.svh"
module testbench import ptp_pkg::*; ;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, start = 1'b0, home = 1'b0, lim = 1'b0, go = 1'b0;
    logic [17:0] addr = 18'h00000;
    logic [15:0] wdata = 16'h0000, rdata, rate = 16'h0000, num = 16'h0000, den = 16'h0000, hwait;
    logic [2:0] haxis = 3'h0, paxis = 3'h0;
    logic [31:0] hpos = 32'h0, speed, v;
    logic rvalid, done, req, hidle, err, run_valid, e, busy, bz;
    logic ce = 1'b1;
    ptp_start_s sreq = '0;
    ptp_run_s run;
    logic [31:0] ceil [8];
    int failures = 0, samples_checked = 0, cycles = 0, n, p, ch;
    logic [15:0] d0, d1;
    ptp_top i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_mem_wr(wr), .i_mem_rd(rd),
        .i_mem_addr(addr), .i_mem_wdata(wdata), .o_mem_rdata(rdata), .o_mem_rvalid(rvalid),
        .i_recalc_req(req), .o_recalc_done(done), .i_start(start), .i_start_req(sreq), .o_start_busy(busy),
        .o_start_err(err), .o_run_valid(run_valid), .o_run(run), .i_home_done(home), .i_home_axis(haxis),
        .i_home_pos(hpos), .i_pulser_axis(paxis), .i_pulser_rate(rate), .i_ratio_num(num),
        .i_ratio_den(den), .i_speed_limit(lim), .o_pulser_speed(speed));
    ptp_host_model i_host (.i_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_recalc_done(done),
        .o_recalc_req(req), .o_idle(hidle), .o_wait(hwait));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // Hang guard: the whole sequence needs about 10200 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            complete_run();
        end
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [17:0] ad(input int a, input int b, input int off);
        return {8'(2 + 10 * a + b), 10'(off)};
    endfunction : ad
    function automatic logic [31:0] spd(input logic [31:0] c, input logic [15:0] r, nm, dn, input logic l);
        logic [31:0] raw;
        logic [31:0] top;
        raw = (dn == 16'h0000) ? 32'h0 : 32'(32'(r) * nm / dn);
        top = (c > `PTP_CEIL_MAX) ? `PTP_CEIL_MAX : c;
        if (!l) begin
            return raw;
        end
        if (c == 32'h0) begin
            return `PTP_MIN_SPEED;
        end
        return (raw > top) ? top : raw;
    endfunction : spd
    task automatic wr_w(input logic [17:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_w
    task automatic rd_w(input logic [17:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask : rd_w
    task automatic sp(input logic [2:0] ax, input logic l);
        @(posedge clk);
        paxis <= ax;
        rate <= 16'($urandom);
        num <= 16'($urandom_range(32767));
        den <= ($urandom_range(7) == 0) ? 16'h0000 : 16'($urandom_range(32767, 1));
        lim <= l;
        repeat (2) @(posedge clk);
        #1;
        check(speed, spd(ceil[ax], rate, num, den, lim));
    endtask : sp
    task automatic st(input int a, input int pt, input int c);
        @(posedge clk);
        start <= 1'b1;
        sreq <= '{3'(a), 14'(pt), 4'(c)};
        n = 0;
        // The refusal pulse follows the accepting edge directly, so watch from that edge on
        do begin
            @(posedge clk);
            start <= 1'b0;
            n++;
            #1;
            if (n == 1) begin
                bz = busy;
            end
        end while (run_valid !== 1'b1 && err !== 1'b1 && n < 40);
        e = err;
    endtask : st
    task automatic recalc();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (hidle !== 1'b1 && n < 700);
        check(hwait, 16'd601);
        check(done, 1'b0);
    endtask : recalc
    initial begin
        void'($urandom(59161));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            ceil[a] = 32'h0;
            rd_w(ad(a, 0, 'h48), 16'h0000);
            rd_w(ad(a, 0, 'h4b), 16'h0000);
        end
        sp(3'h0, 1'b1);
        $display("test reset_values done");
        for (int a = 0; a < 8; a++) begin
            ceil[a] = (a == 0) ? `PTP_CEIL_MAX : (a == 1) ? 32'd32767001 : $urandom_range(`PTP_CEIL_MAX);
            wr_w(ad(a, 0, 'h48), ceil[a][15:0]);
            wr_w(ad(a, 0, 'h49), ceil[a][31:16]);
            wr_w(ad(a, 0, 'h4a), 16'hbeef);
            rd_w(ad(a, 0, 'h48), ceil[a][15:0]);
            rd_w(ad(a, 0, 'h49), ceil[a][31:16]);
            rd_w(ad(a, 0, 'h4a), 16'h0000);
            rd_w(ad(a, 0, 'h4c), 16'h0000);
        end
        rd_w(18'h00048, 16'h0000);
        for (int i = 0; i < 40; i++) sp(3'($urandom_range(7)), 1'($urandom));
        @(posedge clk);
        ce <= 1'b0;
        rate <= ~rate;
        lim <= 1'b0;
        #1;
        v = speed;
        repeat (3) @(posedge clk);
        #1;
        check(speed, v);
        @(posedge clk);
        ce <= 1'b1;
        $display("test ceiling_speed done");
        for (int a = 0; a < 8; a++) begin
            v = $urandom;
            @(posedge clk);
            home <= 1'b1;
            haxis <= 3'(a);
            hpos <= v;
            @(posedge clk);
            home <= 1'b0;
            rd_w(ad(a, 0, 'h4a), v[15:0]);
            rd_w(ad(a, 0, 'h4b), v[31:16]);
        end
        $display("test home_origin done");
        for (int a = 0; a < 8; a++) begin
            p = (a == 0) ? 1 : (a == 7) ? 600 : $urandom_range(600, 1);
            d0 = 16'($urandom);
            d1 = ~d0;
            wr_w(ad(a, 1, p - 1), d0);
            recalc();
            wr_w(ad(a, 1, p - 1), d1);
            st(a, p, 0);
            check(n, 2);
            check(bz, 1'b1);
            check(run, {3'(a), 14'(p), 1'b0, d0});
            recalc();
            st(a, p, 0);
            check(run, {3'(a), 14'(p), 1'b0, d1});
        end
        $display("test standard_area done");
        for (int k = 0; k < 6; k++) begin
            p = (k == 0) ? 10001 : (k == 1) ? 10025 : $urandom_range(10025, 10001);
            ch = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(15);
            d0 = 16'($urandom);
            wr_w(ad(k, 1, p - 10001 + 600), d0);
            st(k, p, ch);
            check(n, 6 + ch);
            check(run, {3'(k), 14'(p), 1'b1, d0});
            check(busy, 1'b0);
        end
        $display("test extended_area done");
        for (int i = 0; i < 5; i++) begin
            p = (i == 0) ? 0 : (i == 1) ? 601 : (i == 2) ? 10000 : (i == 3) ? 10026 : 16383;
            st(i, p, 0);
            check(n, 1);
            check(e, 1'b1);
            check(bz, 1'b0);
        end
        $display("test bad_points done");
        complete_run();
    end
endmodule : testbench
